// ### common/ppc_defines.svh
// Register indices, field codes, masks and reset values of the port pin configuration block
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (word address on the bus)
// ----------------------------------------------------------------
`define PPC_A_DIR0   20'hFFF20
`define PPC_A_DIR1   20'hFFF21
`define PPC_A_DIR2   20'hFFF22
`define PPC_A_DIR7   20'hFFF27
`define PPC_A_LAT0   20'hFFF00
`define PPC_A_LAT1   20'hFFF01
`define PPC_A_LAT2   20'hFFF02
`define PPC_A_LAT7   20'hFFF07
`define PPC_A_IBS0   20'hF0040
`define PPC_A_IBS1   20'hF0041
`define PPC_A_ODS0   20'hF0050
`define PPC_A_ODS1   20'hF0051
`define PPC_A_DAM0   20'hF0060
`define PPC_A_DAM1   20'hF0061
`define PPC_A_DAM4   20'hF0064
`define PPC_A_DAM5   20'hF0065
`define PPC_A_DAM7   20'hF0067
`define PPC_A_CPS    20'hF0076
`define PPC_A_KIR    20'hF0077

// ----------------------------------------------------------------
// Writable bit masks, fixed bits and reset values
// ----------------------------------------------------------------
`define PPC_M_DIR01  8'h7F
`define PPC_F_DIR01  8'h80
`define PPC_M_FULL   8'hFF
`define PPC_M_PORT0  8'h1F
`define PPC_M_PORT1  8'h3F
`define PPC_M_PORT2  8'h1F
`define PPC_M_PORT7  8'h0F
`define PPC_M_IBS0   8'h1B
`define PPC_M_IBS1   8'h33
`define PPC_M_ODS0   8'h1C
`define PPC_M_ODS1   8'h3F
`define PPC_M_DAM0   8'h0C
`define PPC_M_DAM1   8'h3F
`define PPC_M_DAM4   8'h02
`define PPC_M_DAM5   8'h03
`define PPC_M_DAM7   8'h01
`define PPC_M_CPS    8'h07
`define PPC_M_KIR    8'h03
`define PPC_RST_ONES 8'hFF
`define PPC_RST_ZERO 8'h00

// ----------------------------------------------------------------
// Converter pin analog patterns (channels 4..0)
// ----------------------------------------------------------------
`define PPC_AN_ALL   5'h1F
`define PPC_AN_NONE  5'h00
`define PPC_AN_CH0   5'h01
`define PPC_AN_CH01  5'h03
`define PPC_AN_CH02  5'h07
`define PPC_AN_CH03  5'h0F

`endif

// ### common/ppc_pkg.sv
// Types shared by the port pin configuration block
`default_nettype none
`include "ppc_defines.svh"

package ppc_pkg;
   typedef logic [3:0][7:0] ppc_port_type;

   typedef enum logic [2:0] {
      PPC_CPS_ALL_ANALOG = 3'h0,
      PPC_CPS_ALL_DIGITAL = 3'h1,
      PPC_CPS_CH0 = 3'h2,
      PPC_CPS_CH01 = 3'h3,
      PPC_CPS_CH02 = 3'h4,
      PPC_CPS_CH03 = 3'h5
   } ppc_cps_type;

   typedef enum logic [1:0] {
      PPC_KIR_PORT7 = 2'h0,
      PPC_KIR_BAD = 2'h1,
      PPC_KIR_PORT0 = 2'h2,
      PPC_KIR_PORT1 = 2'h3
   } ppc_kir_type;

   localparam int PPC_NREG = 19;
endpackage

`default_nettype wire

// ### rtl/ppc_port_config.sv
// Port pin configuration: mode, buffer, redirection registers and pin control
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.svh"

// What this block does
// - Three-bit converter code sets which converter pins are analog, five pins here.
// - Two-bit redirect code places key inputs on port 7, port 0/2, or port 1.
// - Unavailable key positions have no key function on any pin.
// - Each input buffer bit selects CMOS (0) or TTL (1) input buffer.
// - Each output drive bit set selects N-channel open-drain instead of push-pull.
// - After reset every pin is input with output high impedance.
// - Open-drain output pin with high data floats; drives only low data.
// - No on-chip pull-up in cross-voltage modes; external pull-up required.
// - TTL input applies to the serial and clocked-serial pins of ports 0 and 1.
// - Two-wire channels use pin pairs on ports 0 and 1 in cross-voltage mode.
module ppc_port_config (
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 srst,
   // Avalon-MM register slave
   input  wire logic [19:0]          avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic      [31:0]          avs_readdata,
   output logic                      avs_waitrequest,
   // Pins of ports 0, 1, 2 and 7 (rows 0..3)
   input  wire ppc_pkg::ppc_port_type pin_in,
   output ppc_pkg::ppc_port_type     pin_out,
   output ppc_pkg::ppc_port_type     pin_oe_n,
   output ppc_pkg::ppc_port_type     pin_ttl_sel,
   output ppc_pkg::ppc_port_type     pin_analog,
   // Redirected key inputs
   output logic      [7:0]           key_input
);
   import ppc_pkg::*;

   // ----------------------------------------------------------------
   // Register table
   // ----------------------------------------------------------------
   localparam logic [19:0] ADDR [PPC_NREG] = '{
      `PPC_A_DIR0, `PPC_A_DIR1, `PPC_A_DIR2, `PPC_A_DIR7,
      `PPC_A_LAT0, `PPC_A_LAT1, `PPC_A_LAT2, `PPC_A_LAT7,
      `PPC_A_IBS0, `PPC_A_IBS1, `PPC_A_ODS0, `PPC_A_ODS1,
      `PPC_A_DAM0, `PPC_A_DAM1, `PPC_A_DAM4, `PPC_A_DAM5, `PPC_A_DAM7,
      `PPC_A_CPS, `PPC_A_KIR};
   localparam logic [7:0] MASK [PPC_NREG] = '{
      `PPC_M_DIR01, `PPC_M_DIR01, `PPC_M_FULL, `PPC_M_FULL,
      `PPC_M_PORT0, `PPC_M_PORT1, `PPC_M_PORT2, `PPC_M_PORT7,
      `PPC_M_IBS0, `PPC_M_IBS1, `PPC_M_ODS0, `PPC_M_ODS1,
      `PPC_M_DAM0, `PPC_M_DAM1, `PPC_M_DAM4, `PPC_M_DAM5, `PPC_M_DAM7,
      `PPC_M_CPS, `PPC_M_KIR};
   localparam logic [7:0] RSTV [PPC_NREG] = '{
      `PPC_RST_ONES, `PPC_RST_ONES, `PPC_RST_ONES, `PPC_RST_ONES,
      `PPC_RST_ZERO, `PPC_RST_ZERO, `PPC_RST_ZERO, `PPC_RST_ZERO,
      `PPC_RST_ZERO, `PPC_RST_ZERO, `PPC_RST_ZERO, `PPC_RST_ZERO,
      `PPC_RST_ONES, `PPC_RST_ONES, `PPC_RST_ONES, `PPC_RST_ONES, `PPC_RST_ONES,
      `PPC_RST_ZERO, `PPC_RST_ZERO};
   localparam int S_DIR = 0;
   localparam int S_LAT = 4;
   localparam int S_IBS = 8;
   localparam int S_ODS = 10;
   localparam int S_DAM0 = 12;
   localparam int S_DAM1 = 13;
   localparam int S_DAM7 = 16;
   localparam int S_CPS = 17;
   localparam int S_KIR = 18;

   logic [7:0]  cfg [PPC_NREG];
   logic        ack;
   logic        hit;
   logic [4:0]  slot;
   logic [7:0]  next_rdata;
   logic [4:0]  conv_analog;
   ppc_port_type din;
   ppc_port_type od;

   // ----------------------------------------------------------------
   // Bus slave: one wait cycle, then the answer
   // ----------------------------------------------------------------
   always_comb begin
      hit = 1'b0;
      slot = 5'h00;
      for (int i = 0; i < PPC_NREG; i++) begin
         if (avs_address == ADDR[i]) begin
            hit = 1'b1;
            slot = 5'(i);
         end
      end
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~ack;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read | avs_write) & ~ack;
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      if (hit) begin
         next_rdata = cfg[slot];
         // Port registers show pin level on input pins, latch on output pins
         for (int p = 0; p < 4; p++) begin
            if (slot == 5'(S_LAT + p)) begin
               next_rdata = ((cfg[S_LAT + p] & ~cfg[S_DIR + p]) |
                             (din[p] & cfg[S_DIR + p])) & MASK[S_LAT + p];
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & ~ack) begin
         avs_readdata <= {24'h00_0000, next_rdata};
      end
   end

   // Writes land at the answering edge; unwritable bits keep their fixed value
   always_ff @(posedge core_clk) begin
      if (srst) begin
         for (int i = 0; i < PPC_NREG; i++) begin
            cfg[i] <= RSTV[i];
         end
      end else if (avs_write & ack & hit & avs_byteenable[0]) begin
         cfg[slot] <= (avs_writedata[7:0] & MASK[slot]) |
                      (RSTV[slot] & ~MASK[slot]);
      end
   end

   // ----------------------------------------------------------------
   // Converter pin decode
   // ----------------------------------------------------------------
   always_comb begin
      unique case (ppc_cps_type'(cfg[S_CPS][2:0]))
         PPC_CPS_ALL_ANALOG:  conv_analog = `PPC_AN_ALL;
         PPC_CPS_ALL_DIGITAL: conv_analog = `PPC_AN_NONE;
         PPC_CPS_CH0:         conv_analog = `PPC_AN_CH0;
         PPC_CPS_CH01:        conv_analog = `PPC_AN_CH01;
         PPC_CPS_CH02:        conv_analog = `PPC_AN_CH02;
         PPC_CPS_CH03:        conv_analog = `PPC_AN_CH03;
         // Prohibited codes fall back to digital so no pin floats silently
         default:             conv_analog = `PPC_AN_NONE;
      endcase
   end

   // ----------------------------------------------------------------
   // Per-pin control
   // ----------------------------------------------------------------
   for (genvar p = 0; p < 4; p++) begin : g_port
      for (genvar b = 0; b < 8; b++) begin : g_bit
         logic exist;
         logic ana;
         logic drive;
         assign exist = MASK[S_LAT + p][b];
         if (p == 2) begin : g_conv
            if (b < 5) begin : g_pin
               assign ana = conv_analog[b];
            end else begin : g_none
               assign ana = 1'b0;
            end
         end else begin : g_mode
            // Fixed mode bits read back set but must not kill the pin's digital use
            assign ana = (p == 0) ? cfg[S_DAM0][b] & MASK[S_DAM0][b] :
                         (p == 1) ? cfg[S_DAM1][b] & MASK[S_DAM1][b] :
                                    cfg[S_DAM7][b] & MASK[S_DAM7][b];
         end
         // TTL and open-drain selects exist only on ports 0 and 1
         if (p < 2) begin : g_buf
            assign pin_ttl_sel[p][b] = exist & cfg[S_IBS + p][b];
            assign od[p][b] = cfg[S_ODS + p][b];
         end else begin : g_nobuf
            assign pin_ttl_sel[p][b] = 1'b0;
            assign od[p][b] = 1'b0;
         end
         // Open drain never drives high: high data leaves the pin floating
         assign drive = exist & ~cfg[S_DIR + p][b] & ~ana &
                        ~(od[p][b] & cfg[S_LAT + p][b]);
         // No on-chip pull-up: a floating line relies on the far side's resistor
         assign pin_oe_n[p][b] = ~drive;
         assign pin_out[p][b] = cfg[S_LAT + p][b] & ~od[p][b];
         assign pin_analog[p][b] = exist & ana;
         assign din[p][b] = exist & ~ana & pin_in[p][b];
      end
   end

   // ----------------------------------------------------------------
   // Key input redirection
   // ----------------------------------------------------------------
   always_comb begin
      unique case (ppc_kir_type'(cfg[S_KIR][1:0]))
         PPC_KIR_PORT7: key_input = {4'h0, din[3][3:0]};
         PPC_KIR_PORT0: key_input = {din[2][4:2], din[0][4:0]};
         PPC_KIR_PORT1: key_input = {2'h0, din[1][5:0]};
         PPC_KIR_BAD:   key_input = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence s_cfg_write(logic [19:0] a);
      avs_write & ack & avs_byteenable[0] & (avs_address == a);
   endsequence

   property p_wait_one;
      (avs_read | avs_write) & avs_waitrequest |=> ~avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest held too long");

   property p_reset_hiz;
      $past(srst) |-> (pin_oe_n == '1);
   endproperty
   a_reset_hiz: assert property (p_reset_hiz) else $error("pin driven after reset");

   property p_conv_all;
      (cfg[S_CPS][2:0] == 3'h0) |-> (pin_analog[2][4:0] == `PPC_AN_ALL) & (pin_oe_n[2] == '1);
   endproperty
   a_conv_all: assert property (p_conv_all) else $error("converter pins not analog");

   property p_conv_write;
      s_cfg_write(`PPC_A_CPS) ##0 (avs_writedata[2:0] == 3'h2) |=>
         (pin_analog[2][4:0] == `PPC_AN_CH0);
   endproperty
   a_conv_write: assert property (p_conv_write) else $error("channel 0 code not applied");

   property p_key_bad;
      (cfg[S_KIR][1:0] == 2'h1) |-> (key_input == 8'h00);
   endproperty
   a_key_bad: assert property (p_key_bad) else $error("key input active on bad code");

   property p_key_port1;
      (cfg[S_KIR][1:0] == 2'h3) & ~cfg[S_DAM1][0] |->
         (key_input[0] == pin_in[1][0]) & (key_input[7:6] == 2'h0);
   endproperty
   a_key_port1: assert property (p_key_port1) else $error("port 1 key mapping wrong");

   property p_ttl_write;
      s_cfg_write(`PPC_A_IBS1) |=> (pin_ttl_sel[1] == ($past(avs_writedata[7:0]) & `PPC_M_IBS1));
   endproperty
   a_ttl_write: assert property (p_ttl_write) else $error("buffer select not applied");

   property p_od_float;
      od[0][3] & cfg[S_LAT][3] |-> pin_oe_n[0][3];
   endproperty
   a_od_float: assert property (p_od_float) else $error("open drain drove high");

   property p_od_drive_low;
      s_cfg_write(`PPC_A_ODS1) ##0 avs_writedata[0] ##1
         (~cfg[S_DIR + 1][0] & ~cfg[S_LAT + 1][0] & ~cfg[S_DAM1][0]) |->
         ~pin_oe_n[1][0] & ~pin_out[1][0];
   endproperty
   a_od_drive_low: assert property (p_od_drive_low) else $error("open drain low not driven");

   property p_write_next;
      s_cfg_write(`PPC_A_DIR2) |=> (cfg[S_DIR + 2] == $past(avs_writedata[7:0]));
   endproperty
   a_write_next: assert property (p_write_next) else $error("write not applied next cycle");

   property p_key_port7;
      (cfg[S_KIR][1:0] == 2'h0) & ~cfg[S_DAM7][0] |-> (key_input == {4'h0, pin_in[3][3:0]});
   endproperty
   a_key_port7: assert property (p_key_port7) else $error("port 7 key mapping wrong");

   property p_key_port0;
      (cfg[S_KIR][1:0] == 2'h2) & (cfg[S_CPS][2:0] == 3'h1) & (cfg[S_DAM0][3:2] == 2'h0) |->
         (key_input == {pin_in[2][4:2], pin_in[0][4:0]});
   endproperty
   a_key_port0: assert property (p_key_port0) else $error("port 0 key mapping wrong");

   property p_input_hiz;
      (cfg[S_DIR + 3] == 8'hFF) |-> (pin_oe_n[3] == 8'hFF);
   endproperty
   a_input_hiz: assert property (p_input_hiz) else $error("input pin driven");

   property p_od_never_high;
      (cfg[S_ODS + 1] != 8'h00) |-> ((~pin_oe_n[1] & cfg[S_ODS + 1] & cfg[S_LAT + 1]) == 8'h00);
   endproperty
   a_od_never_high: assert property (p_od_never_high) else $error("open drain drove high");

   property p_conv_none;
      (cfg[S_CPS][2:0] == 3'h1) |-> (pin_analog[2] == 8'h00);
   endproperty
   a_conv_none: assert property (p_conv_none) else $error("converter pin left analog");

endmodule

`default_nettype wire

// ### bench/ppc_pin_model.sv
// Far-side devices on the port pins, pulled up to their own supply
`timescale 1ns/1ps
`default_nettype none

module ppc_pin_model (
   // Block side of each pin
   input  wire ppc_pkg::ppc_port_type pin_out,
   input  wire ppc_pkg::ppc_port_type pin_oe_n,
   // Far devices pulling a line low
   input  wire ppc_pkg::ppc_port_type dev_low,
   // Resolved pin level
   output wire ppc_pkg::ppc_port_type pin_level
);
   import ppc_pkg::*;

   // Wired-AND; a released line rises through the external resistor,
   // never through an on-chip pull-up
   assign pin_level = ~dev_low & (pin_oe_n | pin_out);
endmodule

`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the port pin configuration block
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.svh"

module testbench;
   import ppc_pkg::*;
   // ----------------------------------------------------------
   // Signals and tables
   // ----------------------------------------------------------
   logic         core_clk;
   logic         srst;
   logic [19:0]  avs_address;
   logic         avs_read;
   logic         avs_write;
   logic [31:0]  avs_writedata;
   logic [3:0]   avs_byteenable;
   logic [31:0]  avs_readdata;
   logic         avs_waitrequest;
   wire  ppc_port_type pin_in;
   ppc_port_type pin_out;
   ppc_port_type pin_oe_n;
   ppc_port_type pin_ttl_sel;
   ppc_port_type pin_analog;
   ppc_port_type dev_low;
   logic [7:0]   key_input;
   int           failures;
   int           samples_checked;
   int           seed;
   logic [7:0]   q;
   logic [7:0]   d;
   localparam logic [19:0] reg_addr [16] = '{`PPC_A_DIR0, `PPC_A_DIR1, `PPC_A_DIR2,
      `PPC_A_DIR7, `PPC_A_IBS0, `PPC_A_IBS1, `PPC_A_ODS0, `PPC_A_ODS1, `PPC_A_DAM0,
      `PPC_A_DAM1, `PPC_A_DAM4, `PPC_A_DAM5, `PPC_A_DAM7, `PPC_A_CPS, `PPC_A_KIR, 20'h00ABC};
   localparam logic [7:0] reg_mask [13] = '{`PPC_M_DIR01, `PPC_M_DIR01, 8'hFF, 8'hFF,
      `PPC_M_IBS0, `PPC_M_IBS1, `PPC_M_ODS0, `PPC_M_ODS1, `PPC_M_DAM0, `PPC_M_DAM1,
      `PPC_M_DAM4, `PPC_M_DAM5, `PPC_M_DAM7};
   // Rows 0..3 are ports 0, 1, 2, 7
   localparam ppc_port_type pin_exist = {8'h0F, 8'h1F, 8'h3F, 8'h1F};

   ppc_port_config dut (
      .core_clk        (core_clk),
      .srst            (srst),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .pin_in          (pin_in),
      .pin_out         (pin_out),
      .pin_oe_n        (pin_oe_n),
      .pin_ttl_sel     (pin_ttl_sel),
      .pin_analog      (pin_analog),
      .key_input       (key_input)
   );

   ppc_pin_model far_side (
      .pin_out   (pin_out),
      .pin_oe_n  (pin_oe_n),
      .dev_low   (dev_low),
      .pin_level (pin_in)
   );

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------
   // Expectations, bus and checks
   // ----------------------------------------------------------
   function automatic logic [4:0] an_exp(input logic [2:0] c);
      case (c)
         3'h0: an_exp = 5'h1F;
         3'h2: an_exp = 5'h01;
         3'h3: an_exp = 5'h03;
         3'h4: an_exp = 5'h07;
         3'h5: an_exp = 5'h0F;
         default: an_exp = 5'h00;
      endcase
   endfunction

   // Unlisted positions carry no key function and read 0
   function automatic logic [7:0] key_exp(input logic [1:0] c, input ppc_port_type l);
      case (c)
         2'h0: key_exp = {4'h0, l[3][3:0]};
         2'h2: key_exp = {l[2][4:2], l[0][4:0]};
         2'h3: key_exp = {2'h0, l[1][5:0]};
         default: key_exp = 8'h00;
      endcase
   endfunction

   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
      end
   endtask

   // Holds the request until waitrequest is seen low; bounded wait
   task automatic bus(input logic wr, input logic [19:0] a, input logic [7:0] wd,
                      input logic [3:0] be, output logic [7:0] rd);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= {24'h0, wd};
      avs_byteenable <= be;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         failures++;
         $display("[ERR] %0t bus timeout", $time);
         test_done();
      end
   endtask

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      seed = 29498;
      failures = 0;
      samples_checked = 0;
      srst = 1'b1;
      avs_address = 20'h00000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      dev_low = 32'h0;
      repeat (12) @(posedge core_clk);
      srst <= 1'b0;
      #1;
      check(pin_oe_n, 32'hFFFFFFFF);
      check(pin_analog, 32'h011F3F0C);
      for (int i = 0; i < 16; i++) begin
         bus(1'b0, reg_addr[i], 8'h00, 4'h1, q);
         check(q, (i < 4 || (i > 7 && i < 13)) ? 8'hFF : 8'h00);
      end
      bus(1'b1, reg_addr[15], 8'h5A, 4'h1, q);
      bus(1'b0, reg_addr[15], 8'h00, 4'h1, q);
      check(q, 8'h00);
      bus(1'b1, `PPC_A_KIR, 8'h03, 4'h0, q);
      bus(1'b0, `PPC_A_KIR, 8'h00, 4'h1, q);
      check(q, 8'h00);
      $display("test reset done");
      for (int k = 0; k < 39; k++) begin
         int i;
         logic [7:0] w;
         i = k % 13;
         d = 8'($random(seed)) & reg_mask[i];
         w = d | ((i < 4 || i > 7) ? 8'(~reg_mask[i]) : 8'h00);
         bus(1'b1, reg_addr[i], w, 4'h1, q);
         #1;
         if (i == 4 || i == 5) check(pin_ttl_sel[i-4], d);
         if (i == 8 || i == 9) check(pin_analog[i-8], d);
         if (i == 12) check(pin_analog[3], d);
         bus(1'b0, reg_addr[i], 8'h00, 4'h1, q);
         check(q, w);
      end
      $display("test access done");
      bus(1'b1, `PPC_A_DIR2, 8'hFF, 4'h1, q);
      for (int c = 0; c < 6; c++) begin
         bus(1'b1, `PPC_A_CPS, 8'(c), 4'h1, q);
         #1;
         check(pin_analog[2], {3'h0, an_exp(3'(c))});
      end
      $display("test converter done");
      for (int i = 0; i < 13; i++) bus(1'b1, reg_addr[i], (i < 4) ? 8'hFF : 8'h00, 4'h1, q);
      bus(1'b1, `PPC_A_CPS, 8'h01, 4'h1, q);
      for (int k = 0; k < 15; k++) begin
         logic [1:0] c;
         c = (k < 5) ? 2'h0 : ((k < 10) ? 2'h2 : 2'h3);
         bus(1'b1, `PPC_A_KIR, {6'h0, c}, 4'h1, q);
         dev_low <= $random(seed);
         #1;
         check(key_input, key_exp(c, ~dev_low));
      end
      $display("test key done");
      dev_low <= 32'h0;
      for (int k = 0; k < 20; k++) begin
         int p;
         logic [7:0] lat;
         logic [7:0] od;
         logic [7:0] dr;
         p = k % 2;
         lat = 8'($random(seed)) & pin_exist[p];
         od = 8'($random(seed)) & (p ? `PPC_M_ODS1 : `PPC_M_ODS0);
         dr = 8'($random(seed)) | 8'h80;
         bus(1'b1, p ? `PPC_A_LAT1 : `PPC_A_LAT0, lat, 4'h1, q);
         bus(1'b1, p ? `PPC_A_ODS1 : `PPC_A_ODS0, od, 4'h1, q);
         bus(1'b1, p ? `PPC_A_DIR1 : `PPC_A_DIR0, dr, 4'h1, q);
         #1;
         check(pin_oe_n[p], 8'(~(pin_exist[p] & ~dr & ~(od & lat))));
         check(pin_out[p] & pin_exist[p], 8'(lat & ~od));
         bus(1'b0, p ? `PPC_A_LAT1 : `PPC_A_LAT0, 8'h00, 4'h1, q);
         check(q, 8'(pin_exist[p] & (dr | lat)));
      end
      $display("test drive done");
      bus(1'b1, `PPC_A_LAT1, 8'h03, 4'h1, q);
      bus(1'b1, `PPC_A_ODS1, 8'h03, 4'h1, q);
      bus(1'b1, `PPC_A_IBS1, 8'h03, 4'h1, q);
      bus(1'b1, `PPC_A_DIR1, 8'hFC, 4'h1, q);
      #1;
      check(pin_ttl_sel[1], 8'h03);
      check(pin_oe_n[1][1:0], 2'h3);
      $display("test two wire done");
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      #1;
      check(pin_oe_n, 32'hFFFFFFFF);
      check(pin_analog, 32'h011F3F0C);
      bus(1'b0, `PPC_A_KIR, 8'h00, 4'h1, q);
      check(q, 8'h00);
      $display("test second reset done");
      test_done();
   end
endmodule

`default_nettype wire
